// >>> core/lc_defines.svh
/*
 * Constants of the light curtain status and test-input block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the top module.
 */
// Functional notes
// - Link indicator: blue enabled, blinks during data
// - Beam-code indicator: purple, yellow, blue per option
// - Sender test indicator yellow only during simulation
// - Restart-lock indicator yellow while waiting for restart
// - Output indicator green both on, red off
// - Alignment indicator steady orange with no beam
// - Alignment blinks on partial, off when all aligned
// - Contactor-monitor indicator orange only when enabled
// - Test mode stops all beam emission
// - Test pin high disables test; low enables
// - Short or cross fault forces outputs off
`ifndef LC_DEFINES_SVH
`define LC_DEFINES_SVH

// Register byte offsets
`define LC_ADDR_CFG      8'h00
`define LC_ADDR_STAT     8'h04
`define LC_ADDR_IRQ_STAT 8'h08
`define LC_ADDR_IRQ_CLR  8'h0C
`define LC_ADDR_IRQ_EN   8'h10

// Configuration fields
`define LC_CFG_LINK_EN   0
`define LC_CFG_CODE_LO   1
`define LC_CFG_CODE_HI   2
`define LC_CFG_AUTO      3
`define LC_CFG_CM_EN     4
`define LC_CFG_W         5
`define LC_CFG_RESET     5'h02

// Interrupt event bits
`define LC_EV_FAULT      0
`define LC_EV_TEST       1
`define LC_EV_LOCK       2
`define LC_EV_OFF        3
`define LC_EV_W          4

// Beam-code option encodings
`define LC_CODE_ONE      2'h1
`define LC_CODE_TWO      2'h2
`define LC_CODE_THREE    2'h3

// Blink timing: half period of a 1 Hz blink
`define LC_CLK_KHZ       50000
`define LC_BLINK_HALF_MS 500

`endif

// >>> core/lc_pkg.sv
/*
 * Types of the light curtain status block: indicator colours and the
 * safety output state machine.
 */
package lc_pkg;

    // Indicator colour presented to the LED driver
    typedef enum logic [2:0] {
        COL_OFF    = 3'h0,
        COL_BLUE   = 3'h1,
        COL_PURPLE = 3'h2,
        COL_YELLOW = 3'h3,
        COL_GREEN  = 3'h4,
        COL_RED    = 3'h5,
        COL_ORANGE = 3'h6
    } led_color_t;

    // Safety output states, Gray along locked -> on -> off -> fault
    typedef enum logic [1:0] {
        ST_LOCKED = 2'h0,
        ST_ON     = 2'h1,
        ST_OFF    = 2'h3,
        ST_FAULT  = 2'h2
    } safety_state_t;

endpackage

// >>> core/pin_sync.sv
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are unrelated single-bit levels.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Hold both stages while the clock enable is low
    always_comb begin
        meta_d = ce ? pin_in : meta_q;
        sync_d = ce ? meta_q : sync_q;
    end

    // First stage feeds only the second
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pin_sync_out = sync_q;
endmodule
`default_nettype wire

// >>> core/blink_prescaler.sv
/*
 * Shared blink prescaler: square wave with equal on and off halves.
 * Assumes HALF_CYC of at least one clock cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module blink_prescaler #(
    parameter int HALF_CYC = 25000000
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic ce,
    output logic      blink_phase
);
    localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          phase_q;
    logic          phase_d;
    logic          wrap;

    // Toggle the phase every half period
    always_comb begin
        wrap    = (cnt_q == CW'(HALF_CYC - 1));
        cnt_d   = cnt_q;
        phase_d = phase_q;
        if (ce) begin
            cnt_d   = wrap ? '0 : cnt_q + CW'(1);
            phase_d = wrap ? ~phase_q : phase_q;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q   <= '0;
            phase_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
        end
    end

    assign blink_phase = phase_q;

    AST_HALF_EVEN: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && wrap) |=> (phase_q != $past(phase_q)))
        else $error("blink phase did not toggle at wrap");
endmodule
`default_nettype wire

// >>> core/light_curtain_status_indicators.sv
/*
 * Status indicators, test input and safety output control of a light
 * curtain sender and receiver pair, with a small register port.
 * Assumes one clock, pins that need synchronising, and an optics front
 * end on the same clock that reports how many beams are aligned.
 */
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lc_defines.svh"
module light_curtain_status_indicators
    import lc_pkg::*;
#(
    parameter int BEAM_TOTAL = 8,
    parameter int BEAM_W     = 4,
    parameter int BLINK_HALF_CYC = `LC_BLINK_HALF_MS * `LC_CLK_KHZ
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    input  wire logic [7:0]        addr,
    input  wire logic [31:0]       wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [31:0]       rd_data,
    input  wire logic              test_pin,
    input  wire logic              fault_pin,
    input  wire logic              restart_pin,
    input  wire logic              link_data_active,
    input  wire logic [BEAM_W-1:0] beams_aligned,
    output logic                   beam_emit_en,
    output logic                   safety_output_a,
    output logic                   safety_output_b,
    output logic                   irq,
    output led_color_t             sender_link_led,
    output led_color_t             sender_code_led,
    output led_color_t             sender_test_led,
    output led_color_t             recv_lock_led,
    output led_color_t             recv_output_led,
    output led_color_t             recv_link_led,
    output led_color_t             recv_align_led,
    output led_color_t             recv_contactor_led,
    output led_color_t             recv_code_led
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and blink source

    logic [2:0] pins_s;
    logic       test_s;
    logic       fault_s;
    logic       restart_s;
    logic       blink_phase;

    pin_sync #(.W(3)) u_sync (
        .core_clk     (core_clk),
        .reset_n      (reset_n),
        .ce           (ce),
        .pin_in       ({restart_pin, fault_pin, test_pin}),
        .pin_sync_out (pins_s)
    );

    assign test_s    = pins_s[0];
    assign fault_s   = pins_s[1];
    assign restart_s = pins_s[2];

    blink_prescaler #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .ce          (ce),
        .blink_phase (blink_phase)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register port

    logic [`LC_CFG_W-1:0] cfg_q;
    logic [`LC_CFG_W-1:0] cfg_d;
    logic [`LC_EV_W-1:0]  irq_stat_q;
    logic [`LC_EV_W-1:0]  irq_stat_d;
    logic [`LC_EV_W-1:0]  irq_en_q;
    logic [`LC_EV_W-1:0]  irq_en_d;
    logic [`LC_EV_W-1:0]  events;
    logic [31:0]          rd_data_q;
    logic [31:0]          rd_data_d;
    logic [31:0]          stat_word;
    logic                 link_en;
    logic [1:0]           beam_code;
    logic                 auto_restart;
    logic                 cm_en;

    assign link_en      = cfg_q[`LC_CFG_LINK_EN];
    assign beam_code    = cfg_q[`LC_CFG_CODE_HI:`LC_CFG_CODE_LO];
    assign auto_restart = cfg_q[`LC_CFG_AUTO];
    assign cm_en        = cfg_q[`LC_CFG_CM_EN];

    // Writes, sticky status and read mux; a new event beats a clear
    always_comb begin
        cfg_d      = cfg_q;
        irq_en_d   = irq_en_q;
        irq_stat_d = irq_stat_q;
        rd_data_d  = 32'h0;
        if (ce) begin
            irq_stat_d = irq_stat_q | events;
            if (wr_en) begin
                unique case (addr)
                    `LC_ADDR_CFG:     cfg_d = wr_data[`LC_CFG_W-1:0];
                    `LC_ADDR_IRQ_EN:  irq_en_d = wr_data[`LC_EV_W-1:0];
                    `LC_ADDR_IRQ_CLR: irq_stat_d = (irq_stat_q & ~wr_data[`LC_EV_W-1:0])
                                                   | events;
                    default: ;
                endcase
            end
            if (rd_en) begin
                unique case (addr)
                    `LC_ADDR_CFG:      rd_data_d = {{(32-`LC_CFG_W){1'b0}}, cfg_q};
                    `LC_ADDR_STAT:     rd_data_d = stat_word;
                    `LC_ADDR_IRQ_STAT: rd_data_d = {{(32-`LC_EV_W){1'b0}}, irq_stat_q};
                    `LC_ADDR_IRQ_EN:   rd_data_d = {{(32-`LC_EV_W){1'b0}}, irq_en_q};
                    default:           rd_data_d = 32'h0; // Unmapped and clear read zero
                endcase
            end
        end else begin
            rd_data_d = rd_data_q;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q      <= `LC_CFG_RESET;
            irq_en_q   <= '0;
            irq_stat_q <= '0;
            rd_data_q  <= 32'h0;
        end else begin
            cfg_q      <= cfg_d;
            irq_en_q   <= irq_en_d;
            irq_stat_q <= irq_stat_d;
            rd_data_q  <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;
    assign irq     = |(irq_stat_q & irq_en_q);

    ////////////////////////////////////////////////////////////////////////
    // Test input and safety output state machine

    safety_state_t state_q;
    safety_state_t state_d;
    logic          test_active;
    logic          all_aligned;
    logic          none_aligned;
    logic          field_clear;
    logic          restart_prev_q;
    logic          restart_prev_d;
    logic          restart_rise;
    logic          test_prev_q;
    logic          test_prev_d;

    // A floating pin is pulled low, so loss of the wire also stops beams
    assign test_active  = !test_s;
    assign all_aligned  = (beams_aligned >= BEAM_W'(BEAM_TOTAL));
    assign none_aligned = (beams_aligned == '0);
    assign field_clear  = all_aligned && !test_active;
    assign restart_rise = restart_s && !restart_prev_q;

    // Next state; a fault overrides everything and holds outputs off
    always_comb begin
        state_d        = state_q;
        restart_prev_d = restart_prev_q;
        test_prev_d    = test_prev_q;
        if (ce) begin
            restart_prev_d = restart_s;
            test_prev_d    = test_active;
            if (fault_s) begin
                state_d = ST_FAULT;
            end else begin
                unique case (state_q)
                    ST_LOCKED: begin
                        if (auto_restart) begin
                            state_d = ST_OFF;
                        end else if (field_clear && restart_rise) begin
                            state_d = ST_ON;
                        end
                    end
                    ST_ON: begin
                        if (!field_clear) begin
                            state_d = auto_restart ? ST_OFF : ST_LOCKED;
                        end
                    end
                    ST_OFF: begin
                        if (!auto_restart) begin
                            state_d = ST_LOCKED;
                        end else if (field_clear) begin
                            state_d = ST_ON;
                        end
                    end
                    ST_FAULT: state_d = auto_restart ? ST_OFF : ST_LOCKED;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q        <= ST_LOCKED;
            restart_prev_q <= 1'b0;
            test_prev_q    <= 1'b1; // Matches the synced pin at reset: no false test event, beams dark
        end else begin
            state_q        <= state_d;
            restart_prev_q <= restart_prev_d;
            test_prev_q    <= test_prev_d;
        end
    end

    // Both channels follow one state, so they can never disagree
    assign safety_output_a = (state_q == ST_ON);
    assign safety_output_b = (state_q == ST_ON);
    assign beam_emit_en    = !test_prev_q;

    // Interrupt events, one-cycle pulses on state entry
    always_comb begin
        events                = '0;
        events[`LC_EV_FAULT]  = fault_s && (state_q != ST_FAULT);
        events[`LC_EV_TEST]   = test_active && !test_prev_q;
        events[`LC_EV_LOCK]   = (state_d == ST_LOCKED) && (state_q != ST_LOCKED);
        events[`LC_EV_OFF]    = (state_d != ST_ON) && (state_q == ST_ON);
    end

    assign stat_word = {26'h0, blink_phase, state_q == ST_LOCKED, all_aligned,
                        fault_s, test_active, state_q == ST_ON};

    ////////////////////////////////////////////////////////////////////////
    // Indicator colours, registered for glitch-free LED drive

    led_color_t led_q [9];
    led_color_t led_d [9];
    led_color_t link_col;
    led_color_t code_col;

    always_comb begin
        link_col = !link_en ? COL_OFF :
                   (link_data_active && !blink_phase) ? COL_OFF : COL_BLUE;
        unique case (beam_code)
            `LC_CODE_ONE:   code_col = COL_PURPLE;
            `LC_CODE_TWO:   code_col = COL_YELLOW;
            `LC_CODE_THREE: code_col = COL_BLUE;
            default:        code_col = COL_OFF;
        endcase
        for (int i = 0; i < 9; i++) begin
            led_d[i] = led_q[i];
        end
        if (ce) begin
            led_d[0] = link_col;
            led_d[1] = code_col;
            led_d[2] = test_active ? COL_YELLOW : COL_OFF;
            led_d[3] = (state_q == ST_LOCKED && !auto_restart) ? COL_YELLOW : COL_OFF;
            led_d[4] = (state_q == ST_ON) ? COL_GREEN : COL_RED;
            led_d[5] = link_col;
            led_d[6] = none_aligned ? COL_ORANGE :
                       all_aligned  ? COL_OFF :
                       (blink_phase ? COL_ORANGE : COL_OFF);
            led_d[7] = cm_en ? COL_ORANGE : COL_OFF;
            led_d[8] = code_col;
        end
    end

    // Indicators come up dark until the first enabled cycle fills them
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 9; i++) begin
                led_q[i] <= COL_OFF;
            end
        end else begin
            led_q <= led_d;
        end
    end

    assign sender_link_led    = led_q[0];
    assign sender_code_led    = led_q[1];
    assign sender_test_led    = led_q[2];
    assign recv_lock_led      = led_q[3];
    assign recv_output_led    = led_q[4];
    assign recv_link_led      = led_q[5];
    assign recv_align_led     = led_q[6];
    assign recv_contactor_led = led_q[7];
    assign recv_code_led      = led_q[8];

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_LINK_OFF: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && !link_en) |=> (recv_link_led == COL_OFF && sender_link_led == COL_OFF))
        else $error("link indicator lit while link disabled");
    AST_LINK_STEADY: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && link_en && !link_data_active) |=> (recv_link_led == COL_BLUE))
        else $error("link indicator not steady blue");
    AST_CODE_TWO: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && beam_code == `LC_CODE_TWO) |=> (sender_code_led == COL_YELLOW
                                               && recv_code_led == COL_YELLOW))
        else $error("beam-code two not yellow");
    AST_TEST_LED: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && $stable(test_active)) |=> (sender_test_led ==
                                          ($past(test_active) ? COL_YELLOW : COL_OFF)))
        else $error("test indicator wrong");
    AST_LOCK_AUTO: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && auto_restart) |=> (recv_lock_led == COL_OFF))
        else $error("lock indicator lit in automatic restart");
    AST_OUT_LED: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && safety_output_a) |=> (recv_output_led == COL_GREEN))
        else $error("output indicator not green with outputs on");
    AST_ALIGN_NONE: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && none_aligned) |=> (recv_align_led == COL_ORANGE))
        else $error("alignment not steady orange with no beam");
    AST_ALIGN_PART: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && !none_aligned && !all_aligned)
        |=> (recv_align_led == ($past(blink_phase) ? COL_ORANGE : COL_OFF)))
        else $error("partial alignment blink wrong");
    AST_CM_LED: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && cm_en) |=> (recv_contactor_led == COL_ORANGE))
        else $error("contactor indicator not orange");
    AST_EMIT_STOP: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && test_active) |=> !beam_emit_en ##0 !safety_output_a)
        else $error("beams still emitted in test mode");
    AST_PIN_LOW: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && !test_s) |=> (!safety_output_a && !safety_output_b))
        else $error("low test pin did not simulate intrusion");
    AST_FAULT_OFF: assert property (@(posedge core_clk) disable iff (!reset_n)
        (ce && fault_s) |=> (!safety_output_a && !safety_output_b))
        else $error("outputs on during fault");
endmodule
`default_nettype wire

// >>> tb/lc_operator.sv
/*
 * Model of the operator and the machine control that drive the sender
 * test pin, the fault sense pin and the restart push button.
 * Assumes the bench clock, one-cycle restart pulses and held test and fault request levels from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module lc_operator (
    input  wire logic       core_clk,
    input  wire logic       test_req,
    input  wire logic       fault_req,
    input  wire logic       restart_req,
    input  wire logic [7:0] press_len,
    output logic            test_pin,
    output logic            fault_pin,
    output logic            restart_pin
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pins start in normal running: test input high, no fault, button up
    logic [7:0] hold_q  = 8'h00;
    logic       test_q  = 1'b1;
    logic       fault_q = 1'b0;
    logic       press_q = 1'b0;

    assign test_pin    = test_q;
    assign fault_pin   = fault_q;
    assign restart_pin = press_q;

    // Control keeps the test input high unless a test is asked for;
    // the button is held for a random time, so short and long presses occur
    always @(posedge core_clk) begin
        test_q <= ~test_req;
        fault_q <= fault_req;
        press_q <= (hold_q != 8'h00);
        if (restart_req) begin
            hold_q <= press_len;
        end else if (hold_q != 8'h00) begin
            hold_q <= hold_q - 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> tb/light_curtain_status_indicators_tb_top.sv
/*
 * Self-checking bench of the status indicator block: bus tasks, a queue of
 * expected results and a monitor that compares them on the falling edge.
 * Assumes the design package, the operator model and a short blink count.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module light_curtain_status_indicators_tb_top;
    import lc_pkg::*;
    typedef struct { int sel; logic [31:0] exp; } note_t;
    ////////////////////////////////////////////////////////////////////////////////
    logic        core_clk = 1'b0, reset_n = 1'b0, ce = 1'b1;
    logic [7:0]  addr = 8'h00, press_len = 8'h01;
    logic [31:0] wr_data = 32'h0, rd_data, cnt_a = 32'h0, cnt_b = 32'h0;
    logic        wr_en = 1'b0, rd_en = 1'b0, link_data_active = 1'b0;
    logic [3:0]  beams_aligned = 4'h0;
    logic        test_req = 1'b0, fault_req = 1'b0, restart_req = 1'b0;
    logic        test_pin, fault_pin, restart_pin, beam_emit_en, irq;
    logic        safety_output_a, safety_output_b;
    led_color_t  sender_link_led, sender_code_led, sender_test_led, recv_lock_led;
    led_color_t  recv_output_led, recv_link_led, recv_align_led, recv_contactor_led;
    led_color_t  recv_code_led;
    led_color_t  code_col [4] = '{COL_OFF, COL_PURPLE, COL_YELLOW, COL_BLUE};
    logic [31:0] obs [16];
    note_t       q [$];
    int          num_errors = 0, cmp_count = 0;
    string       nm [16] = '{"rd_data", "beam_emit", "out_a", "out_b", "irq", "s_link",
        "s_code", "s_test", "r_lock", "r_out", "r_link", "r_align", "r_cont", "r_code",
        "align_on_cnt", "link_on_cnt"};

    always #10 core_clk = ~core_clk;

    // Short blink half period keeps the run brief
    light_curtain_status_indicators #(.BEAM_TOTAL(8), .BEAM_W(4), .BLINK_HALF_CYC(8)) u_dut (
        .core_clk, .reset_n, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .test_pin,
        .fault_pin, .restart_pin, .link_data_active, .beams_aligned, .beam_emit_en,
        .safety_output_a, .safety_output_b, .irq, .sender_link_led, .sender_code_led,
        .sender_test_led, .recv_lock_led, .recv_output_led, .recv_link_led, .recv_align_led,
        .recv_contactor_led, .recv_code_led);

    lc_operator u_operator (.core_clk, .test_req, .fault_req, .restart_req, .press_len,
        .test_pin, .fault_pin, .restart_pin);

    // Observed values by index, widened to one word
    assign obs = '{rd_data, 32'(beam_emit_en), 32'(safety_output_a), 32'(safety_output_b),
        32'(irq), 32'(sender_link_led), 32'(sender_code_led), 32'(sender_test_led),
        32'(recv_lock_led), 32'(recv_output_led), 32'(recv_link_led), 32'(recv_align_led),
        32'(recv_contactor_led), 32'(recv_code_led), cnt_a, cnt_b};

    ////////////////////////////////////////////////////////////////////////////////
    // Notes are pushed just after a rising edge and judged at the next falling edge
    always @(negedge core_clk) begin
        while (q.size() > 0) begin
            note_t n;
            n = q.pop_front();
            `CHK(nm[n.sel], n.exp, obs[n.sel])
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic chk(input int s, input logic [31:0] e);
        q.push_back('{s, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        chk(0, e);
    endtask

    task automatic press();
        @(posedge core_clk);
        restart_req <= 1'b1;
        press_len <= 8'($urandom_range(1, 20));
        @(posedge core_clk);
        restart_req <= 1'b0;
        tick(30);
    endtask

    // Counts lit cycles over two whole blink periods
    task automatic count32();
        cnt_a = 32'h0;
        cnt_b = 32'h0;
        repeat (32) begin
            @(posedge core_clk);
            #1;
            if (recv_align_led === COL_ORANGE) cnt_a++;
            if (recv_link_led === COL_BLUE) cnt_b++;
        end
    endtask

    task automatic results();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(20000);
        num_errors++;
        results();
    end

    initial begin
        void'($urandom(32'h637D));
        tick(2);
        reset_n <= 1'b1;
        tick(8);
        rd(8'h00, 32'h02);
        rd(8'h10, 32'h0);
        rd(8'h0C, 32'h0);
        rd(8'h14, 32'h0);
        wr(8'h0C, 32'h1F);
        rd(8'h08, 32'h0);
        // Every beam code, with link and contactor monitor both ways
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, {27'h0, c[0], 1'b0, c[1:0], c[1]});
            tick(3);
            chk(6, code_col[c]);
            chk(13, code_col[c]);
            chk(12, c[0] ? COL_ORANGE : COL_OFF);
            chk(10, c[1] ? COL_BLUE : COL_OFF);
            chk(5, c[1] ? COL_BLUE : COL_OFF);
        end
        count32();
        chk(14, 32'd32);
        chk(15, 32'd32);
        beams_aligned <= 4'($urandom_range(1, 7));
        link_data_active <= 1'b1;
        tick(3);
        count32();
        chk(14, 32'd16);
        chk(15, 32'd16);
        press();
        chk(9, COL_RED);
        beams_aligned <= 4'h8;
        tick(4);
        chk(11, COL_OFF);
        chk(8, COL_YELLOW);
        chk(2, 32'h0);
        press();
        chk(2, 32'h1);
        chk(3, 32'h1);
        chk(9, COL_GREEN);
        chk(8, COL_OFF);
        // Fault while running: outputs drop and stay down, events latch
        fault_req <= 1'b1;
        tick(6);
        chk(2, 32'h0);
        chk(9, COL_RED);
        tick(40);
        chk(3, 32'h0);
        chk(4, 32'h0);
        rd(8'h08, 32'h09);
        wr(8'h10, 32'h01);
        tick(1);
        chk(4, 32'h1);
        wr(8'h0C, 32'h09);
        tick(1);
        chk(4, 32'h0);
        rd(8'h08, 32'h0);
        fault_req <= 1'b0;
        tick(6);
        chk(8, COL_YELLOW);
        // Test input low halts emission and drops safety output a
        press();
        test_req <= 1'b1;
        tick(6);
        chk(1, 32'h0);
        chk(7, COL_YELLOW);
        chk(2, 32'h0);
        test_req <= 1'b0;
        tick(6);
        chk(1, 32'h1);
        chk(7, COL_OFF);
        // Automatic restart: no lock, outputs follow the field
        wr(8'h00, 32'h08);
        tick(6);
        chk(8, COL_OFF);
        chk(9, COL_GREEN);
        beams_aligned <= 4'($urandom_range(1, 7));
        tick(6);
        chk(9, COL_RED);
        chk(3, 32'h0);
        beams_aligned <= 4'h8;
        tick(6);
        chk(3, 32'h1);
        // Clock enable low freezes every state although the field breaks
        ce <= 1'b0;
        beams_aligned <= 4'h0;
        tick(6);
        chk(3, 32'h1);
        chk(11, COL_OFF);
        ce <= 1'b1;
        tick(3);
        chk(3, 32'h0);
        chk(11, COL_ORANGE);
        tick(2);
        results();
    end
endmodule
`default_nettype wire
